// ---- hw/rst_sleep_ctrl.sv ----
// Reset, sleep and wake-up sequencer with APB register slave
//
// What this block does
// - Reset from power-on, reset pin, watchdog.
// - Hold reset one start-up period, 18 ms.
// - Reset runs oscillator, presets program counter ones.
// - Power-on only clears status 5-6, bank 7-6.
// - Reset puts all port pins high-impedance.
// - Reset clears watchdog and prescaler counters.
// - Reset sets timer option except bit 6.
// - Reset sets port-6 wake mask all ones.
// - Reset clears control bits 3,6; sets 0,4,5.
// - Reset clears interrupt flag/mask bits 0,3.
// - Sleep instruction enters sleep 1, clears watchdog.
// - Sleep 1 left only by reset.
// - Time-out and power-down flags show wake cause.
// - Clearing sleep-control bit enters sleep 2.
// - Enabled wake pin low resumes without reset.
// - Pin wake enables watchdog when option is 0.
// - Sleep 2 reset pin or time-out resets.
// - Wake sets sleep bit; its edges gate oscillator.
// - Wake mask bit 0 enables, 1 disables.
// - Enable bit counts only while option is 0.
`timescale 1ns/1ns
module rst_sleep_ctrl
  import rst_sleep_pkg::*;
#(
  parameter int unsigned OST_CYCLES = rst_sleep_pkg::OST_CYCLES_DEF,
  parameter int unsigned WDT_CYCLES = rst_sleep_pkg::WDT_CYCLES_DEF
)(
  // Clock and power-on reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core events, same clock
  input  wire logic        sleep_instruction,
  input  wire logic        watchdog_clear,
  // Pins
  input  wire logic        reset_pin_n,
  input  wire logic [7:0]  port6_wake_pins,
  input  wire logic [1:0]  port7_wake_pins,
  input  wire logic        watchdog_code_option,
  // Control to core and pads
  output logic             cpu_reset,
  output logic             cpu_stall,
  output logic             osc_enable,
  output logic             program_counter_preset,
  output logic             ports_hiz
);
  import rst_sleep_pkg::*;

  // Refused at elaboration: a zero period would wrap OST_LAST or WDT_LAST to all ones
  if (OST_CYCLES < 1 || WDT_CYCLES < 1)
  begin : g_bad_period
    $error("Start-up and watchdog periods need at least one cycle");
  end

  localparam logic [31:0] OST_LAST = 32'(OST_CYCLES - 1);
  localparam logic [31:0] WDT_LAST = 32'(WDT_CYCLES - 1);

  pwr_state_type st_q, st_d;
  logic [31:0]   ost_cnt_q, wdt_cnt_q;
  logic [7:0]    pre_cnt_q;
  logic [7:0]    status_word_q, bank_select_register_q, timer_option_register_q;
  logic [7:0]    port6_wake_mask_q, watchdog_sleep_control_q;
  logic [7:0]    interrupt_flag_register_q, interrupt_mask_register_q;
  logic [2:0]    cause_q;
  logic [1:0]    rst_sync_q, opt_sync_q;
  logic [7:0]    p6_s1_q, p6_s2_q;
  logic [1:0]    p7_s1_q, p7_s2_q;
  logic          pready_q, pslverr_q;
  logic [31:0]   prdata_q;
  logic          cpu_reset_q, cpu_stall_q, osc_enable_q, pc_preset_q, ports_hiz_q;

  // Pins cross in through two flops; nothing reads the first stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_sync_q <= 2'b00;
      opt_sync_q <= 2'b00;
      p6_s1_q    <= 8'hFF;
      p6_s2_q    <= 8'hFF;
      p7_s1_q    <= 2'b11;
      p7_s2_q    <= 2'b11;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], reset_pin_n};
      opt_sync_q <= {opt_sync_q[0], watchdog_code_option};
      p6_s1_q    <= port6_wake_pins;
      p6_s2_q    <= p6_s1_q;
      p7_s1_q    <= port7_wake_pins;
      p7_s2_q    <= p7_s1_q;
    end
  end

  logic pin_ok, wdt_on, wdt_tick, wdt_to, wake_hit, hold;
  logic wr_en, rd_en, sleep_control_bit_fall, sleep_control_bit_rise;
  assign hold     = (st_q == ST_HOLD);
  assign pin_ok   = rst_sync_q[1];
  // Option 1 leaves the watchdog off whatever the enable bit says
  assign wdt_on   = !opt_sync_q[1] && watchdog_sleep_control_q[WSC_WATCHDOG_ENABLE_BIT_BIT];
  assign wake_hit = |(~p6_s2_q & ~port6_wake_mask_q)
                    || (!watchdog_sleep_control_q[WSC_WUE_BIT] && !(&p7_s2_q));
  assign wr_en    = psel && penable && pready_q && pwrite;
  assign rd_en    = psel && penable && !pready_q;
  assign sleep_control_bit_fall = wr_en && paddr == OFS_WDT_SLEEP && !pwdata[WSC_SLEEP_CONTROL_BIT_BIT]
                     && watchdog_sleep_control_q[WSC_SLEEP_CONTROL_BIT_BIT];
  assign sleep_control_bit_rise = wr_en && paddr == OFS_WDT_SLEEP && pwdata[WSC_SLEEP_CONTROL_BIT_BIT]
                     && !watchdog_sleep_control_q[WSC_SLEEP_CONTROL_BIT_BIT];

  function automatic logic [7:0] wdt_last(input logic [7:0] opt);
    wdt_last = opt[OPT_PAB_BIT] ? 8'((9'h001 << opt[2:0]) - 9'h001) : 8'h00;
  endfunction

  // Watchdog keeps counting in both sleeps, as its own RC clock would
  assign wdt_tick = (wdt_cnt_q == WDT_LAST);
  assign wdt_to   = wdt_on && !hold && wdt_tick
                    && (pre_cnt_q == wdt_last(timer_option_register_q));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdt_cnt_q <= 32'h0000_0000;
      pre_cnt_q <= 8'h00;
    end
    else if (hold || !wdt_on || watchdog_clear || wdt_to
             || (st_q == ST_RUN && sleep_instruction))
    begin
      wdt_cnt_q <= 32'h0000_0000;
      pre_cnt_q <= 8'h00;
    end
    else if (wdt_tick)
    begin
      wdt_cnt_q <= 32'h0000_0000;
      pre_cnt_q <= pre_cnt_q + 8'h01;
    end
    else
      wdt_cnt_q <= wdt_cnt_q + 32'h0000_0001;
  end

  // Power state sequence
  always_comb
  begin
    st_d = st_q;
    if (!pin_ok || wdt_to)
      st_d = ST_HOLD;
    else
    begin
      case (st_q)
        ST_HOLD:   if (ost_cnt_q == OST_LAST) st_d = ST_RUN;
        ST_RUN:
        begin
          if (sleep_instruction)
            st_d = ST_SLEEP1;
          else if (sleep_control_bit_fall)
            st_d = ST_SLEEP2;
        end
        ST_SLEEP1: st_d = ST_SLEEP1;
        ST_SLEEP2: if (wake_hit || sleep_control_bit_rise) st_d = ST_WOST;
        ST_WOST:   if (ost_cnt_q == OST_LAST) st_d = ST_RUN;
        default:   st_d = ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q      <= ST_HOLD;
      ost_cnt_q <= 32'h0000_0000;
    end
    else
    begin
      st_q <= st_d;
      // Start-up count restarts while the pin is still low
      if (st_d != st_q || !pin_ok)
        ost_cnt_q <= 32'h0000_0000;
      else if ((hold || st_q == ST_WOST) && ost_cnt_q != OST_LAST)
        ost_cnt_q <= ost_cnt_q + 32'h0000_0001;
    end
  end

  // Outputs to core and pads
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_reset_q  <= 1'b1;
      cpu_stall_q  <= 1'b1;
      osc_enable_q <= 1'b1;
      pc_preset_q  <= 1'b1;
      ports_hiz_q  <= 1'b1;
    end
    else
    begin
      cpu_reset_q  <= (st_d == ST_HOLD);
      cpu_stall_q  <= (st_d != ST_RUN);
      osc_enable_q <= (st_d != ST_SLEEP1) && (st_d != ST_SLEEP2);
      pc_preset_q  <= (st_d == ST_HOLD);
      ports_hiz_q  <= (st_d == ST_HOLD);
    end
  end

  // Status word and bank select: reset only by power-on, status to 8'h18 and bank to 8'h00
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_word_q          <= 8'h18 & ~ST_POR_CLR;
      bank_select_register_q <= 8'h00 & ~BANK_POR_CLR;
    end
    else
    begin
      if (wr_en && paddr == OFS_STATUS)
        status_word_q <= (pwdata[7:0] & ~ST_RO_MASK) | (status_word_q & ST_RO_MASK);
      if (wdt_to)
        status_word_q[ST_TO_BIT] <= 1'b0;
      else if (watchdog_clear)
      begin
        status_word_q[ST_TO_BIT] <= 1'b1;
        status_word_q[ST_PD_BIT] <= 1'b1;
      end
      else if (st_q == ST_RUN && (sleep_instruction || sleep_control_bit_fall))
      begin
        status_word_q[ST_TO_BIT] <= 1'b1;
        status_word_q[ST_PD_BIT] <= 1'b0;
      end
      if (wr_en && paddr == OFS_BANK)
        bank_select_register_q <= pwdata[7:0];
    end
  end

  // Control registers: forced to reset values while held, except timer option bit 6, which keeps its value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_option_register_q   <= OPT_RST;
      port6_wake_mask_q         <= WAKE6_RST;
      watchdog_sleep_control_q  <= WSC_RST;
      interrupt_flag_register_q <= INT_RST;
      interrupt_mask_register_q <= INT_RST;
    end
    else if (hold)
    begin
      timer_option_register_q   <= (timer_option_register_q & OPT_KEEP)
                                   | (OPT_RST & ~OPT_KEEP);
      port6_wake_mask_q         <= WAKE6_RST;
      watchdog_sleep_control_q  <= WSC_RST;
      interrupt_flag_register_q <= INT_RST;
      interrupt_mask_register_q <= INT_RST;
    end
    else
    begin
      if (wr_en && paddr == OFS_OPTION)
        timer_option_register_q <= pwdata[7:0];
      if (wr_en && paddr == OFS_WAKE6)
        port6_wake_mask_q <= pwdata[7:0];
      if (wr_en && paddr == OFS_WDT_SLEEP)
        watchdog_sleep_control_q <= pwdata[7:0] & WSC_USED;
      // Hardware set beats a software clear in the same cycle
      if (st_q == ST_SLEEP2 && wake_hit)
      begin
        watchdog_sleep_control_q[WSC_SLEEP_CONTROL_BIT_BIT] <= 1'b1;
        if (!opt_sync_q[1])
          watchdog_sleep_control_q[WSC_WATCHDOG_ENABLE_BIT_BIT] <= 1'b1;
      end
      if (wr_en && paddr == OFS_INT_FLAG)
        interrupt_flag_register_q <= pwdata[7:0] & INT_USED;
      if (wr_en && paddr == OFS_INT_MASK)
        interrupt_mask_register_q <= pwdata[7:0] & INT_USED;
    end
  end

  // Last reset cause: {watchdog, pin, power-on}
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cause_q <= 3'b001;
    else if (wdt_to)
      cause_q <= 3'b100;
    else if (!pin_ok && !hold)
      cause_q <= 3'b010;
  end

  // APB: one wait state, read data captured with pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= rd_en;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      if (rd_en)
      begin
        case (paddr)
          OFS_STATUS:    prdata_q[7:0] <= status_word_q;
          OFS_BANK:      prdata_q[7:0] <= bank_select_register_q;
          OFS_OPTION:    prdata_q[7:0] <= timer_option_register_q;
          OFS_WAKE6:     prdata_q[7:0] <= port6_wake_mask_q;
          OFS_WDT_SLEEP: prdata_q[7:0] <= watchdog_sleep_control_q;
          OFS_INT_FLAG:  prdata_q[7:0] <= interrupt_flag_register_q;
          OFS_INT_MASK:  prdata_q[7:0] <= interrupt_mask_register_q;
          OFS_CAUSE:     prdata_q[7:0] <= {2'b00, st_q, cause_q};
          // Unmapped writes are ignored without an error
          default:       pslverr_q <= !pwrite;
        endcase
      end
    end
  end

  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign cpu_reset              = cpu_reset_q;
  assign cpu_stall              = cpu_stall_q;
  assign osc_enable             = osc_enable_q;
  assign program_counter_preset = pc_preset_q;
  assign ports_hiz              = ports_hiz_q;

  property p_pin_reset;
    @(posedge pclk) disable iff (!presetn) !pin_ok |=> st_q == ST_HOLD;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin low did not reset");

  property p_ost_hold;
    @(posedge pclk) disable iff (!presetn)
      hold && pin_ok && !wdt_to && ost_cnt_q != OST_LAST |=> hold && cpu_reset;
  endproperty
  a_ost_hold: assert property (p_ost_hold) else $error("left reset early");

  property p_osc_pc;
    @(posedge pclk) disable iff (!presetn) hold |-> osc_enable && program_counter_preset;
  endproperty
  a_osc_pc: assert property (p_osc_pc) else $error("reset without osc or pc preset");

  property p_hiz;
    @(posedge pclk) disable iff (!presetn) hold |-> ports_hiz;
  endproperty
  a_hiz: assert property (p_hiz) else $error("ports not high-z in reset");

  property p_wdt_clr;
    @(posedge pclk) disable iff (!presetn)
      hold |=> wdt_cnt_q == 32'h0000_0000 && pre_cnt_q == 8'h00;
  endproperty
  a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog not cleared");

  property p_mask;
    @(posedge pclk) disable iff (!presetn)
      hold |=> port6_wake_mask_q == WAKE6_RST && watchdog_sleep_control_q == WSC_RST;
  endproperty
  a_mask: assert property (p_mask) else $error("reset values not loaded");

  property p_sleep1;
    @(posedge pclk) disable iff (!presetn)
      st_q == ST_RUN && sleep_instruction && pin_ok && !wdt_to
      |=> st_q == ST_SLEEP1 && wdt_cnt_q == 32'h0000_0000 && !osc_enable;
  endproperty
  a_sleep1: assert property (p_sleep1) else $error("sleep 1 entry wrong");

  property p_stay1;
    @(posedge pclk) disable iff (!presetn)
      st_q == ST_SLEEP1 && pin_ok && !wdt_to |=> st_q == ST_SLEEP1;
  endproperty
  a_stay1: assert property (p_stay1) else $error("sleep 1 left without reset");

  property p_wake;
    @(posedge pclk) disable iff (!presetn)
      st_q == ST_SLEEP2 && wake_hit && pin_ok && !wdt_to
      |=> st_q == ST_WOST && watchdog_sleep_control_q[WSC_SLEEP_CONTROL_BIT_BIT] ##1 osc_enable;
  endproperty
  a_wake: assert property (p_wake) else $error("pin wake failed");

  c_wdt_reset: cover property (@(posedge pclk) disable iff (!presetn) wdt_to ##1 hold);
  c_sleep2:    cover property (@(posedge pclk) disable iff (!presetn)
                               st_q == ST_SLEEP2 ##[1:50] st_q == ST_WOST);
  c_run:       cover property (@(posedge pclk) disable iff (!presetn) hold ##1 st_q == ST_RUN);
endmodule // rst_sleep_ctrl

// ---- hw/rst_sleep_pkg.sv ----
// Constants for the reset, sleep and wake-up controller
package rst_sleep_pkg;
  // Timing: start-up and watchdog periods
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned OST_TIME_US     = 18000;
  localparam int unsigned WDT_TIME_US     = 18000;
  localparam int unsigned OST_CYCLES_DEF  = OST_TIME_US * CLK_MHZ;
  localparam int unsigned WDT_CYCLES_DEF  = WDT_TIME_US * CLK_MHZ;

  // Register byte offsets
  localparam logic [7:0] OFS_STATUS    = 8'h00;
  localparam logic [7:0] OFS_BANK      = 8'h04;
  localparam logic [7:0] OFS_OPTION    = 8'h08;
  localparam logic [7:0] OFS_WAKE6     = 8'h0C;
  localparam logic [7:0] OFS_WDT_SLEEP = 8'h10;
  localparam logic [7:0] OFS_INT_FLAG  = 8'h14;
  localparam logic [7:0] OFS_INT_MASK  = 8'h18;
  localparam logic [7:0] OFS_CAUSE     = 8'h1C;

  // Status word fields
  localparam int unsigned ST_TO_BIT    = 4;
  localparam int unsigned ST_PD_BIT    = 3;
  localparam logic [7:0]  ST_POR_CLR   = 8'h60;
  localparam logic [7:0]  ST_RO_MASK   = 8'h18;
  localparam logic [7:0]  BANK_POR_CLR = 8'hC0;

  // Timer option fields
  localparam logic [7:0]  OPT_RST      = 8'hBF;
  localparam logic [7:0]  OPT_KEEP     = 8'h40;
  localparam int unsigned OPT_PAB_BIT  = 3;

  // Watchdog/sleep control fields
  localparam logic [7:0]  WSC_RST      = 8'h31;
  localparam logic [7:0]  WSC_USED     = 8'h79;
  localparam int unsigned WSC_WUE_BIT  = 0;
  localparam int unsigned WSC_SLEEP_CONTROL_BIT_BIT = 4;
  localparam int unsigned WSC_WATCHDOG_ENABLE_BIT_BIT = 5;

  localparam logic [7:0]  WAKE6_RST    = 8'hFF;
  localparam logic [7:0]  INT_USED     = 8'h09;
  localparam logic [7:0]  INT_RST      = 8'h00;

  typedef enum logic [2:0] {
    ST_HOLD   = 3'b000,
    ST_RUN    = 3'b001,
    ST_SLEEP1 = 3'b010,
    ST_SLEEP2 = 3'b011,
    ST_WOST   = 3'b100
  } pwr_state_type;
endpackage

// ---- testbench/rst_sleep_ctrl_tb.sv ----
// Self-checking bench for the reset, sleep and wake-up controller
`timescale 1ns/1ns
module rst_sleep_ctrl_tb;
  import rst_sleep_pkg::*;
  // Short counts keep the run small
  localparam int unsigned OSCILLATOR_STARTUP_TIMER = 20;
  localparam int unsigned WDT = 30;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sleep_instruction;
  logic        watchdog_clear;
  logic        reset_pin_n;
  logic [7:0]  port6_wake_pins;
  logic [1:0]  port7_wake_pins;
  logic        watchdog_code_option;
  logic        cpu_reset;
  logic        cpu_stall;
  logic        osc_enable;
  logic        program_counter_preset;
  logic        ports_hiz;
  logic [31:0] rd;
  logic        err;
  int          rst_seen = 0;
  int          fails;
  int          comparisons;
  int          cyc = 0;
  int          n;
  int          m;

  rst_sleep_ctrl #(.OST_CYCLES(OSCILLATOR_STARTUP_TIMER), .WDT_CYCLES(WDT)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_instruction(sleep_instruction), .watchdog_clear(watchdog_clear),
    .reset_pin_n(reset_pin_n), .port6_wake_pins(port6_wake_pins),
    .port7_wake_pins(port7_wake_pins), .watchdog_code_option(watchdog_code_option),
    .cpu_reset(cpu_reset), .cpu_stall(cpu_stall), .osc_enable(osc_enable),
    .program_counter_preset(program_counter_preset), .ports_hiz(ports_hiz)
  );

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cpu_reset === 1'b1)
      rst_seen <= rst_seen + 1;
    if (cyc == 20000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits on a level; running out of cycles counts as a mismatch
  task automatic wait_sig(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v && k < lim)
    begin
      @(posedge pclk);
      k++;
    end
    chk(s, v);
  endtask

  // Held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd  = prdata;
    err = pslverr;
    chk(pready, 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pulse(input logic sleep_not_clear);
    if (sleep_not_clear)
      sleep_instruction <= 1'b1;
    else
      watchdog_clear <= 1'b1;
    @(posedge pclk);
    sleep_instruction <= 1'b0;
    watchdog_clear    <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pin_reset();
    reset_pin_n <= 1'b0;
    wait_sig(cpu_reset, 1'b1, 8, n);
    chk({osc_enable, program_counter_preset, ports_hiz}, 3'b111);
    reset_pin_n <= 1'b1;
    wait_sig(cpu_stall, 1'b0, OSCILLATOR_STARTUP_TIMER + 12, n);
  endtask

  task automatic t_power_on();
    chk({cpu_reset, osc_enable, program_counter_preset, ports_hiz}, 4'hF);
    wait_sig(cpu_reset, 1'b0, OSCILLATOR_STARTUP_TIMER + 10, n);
    chk(n >= OSCILLATOR_STARTUP_TIMER, 1'b1);
    apb(1'b0, OFS_OPTION, 0);
    chk(rd, 32'h0000_00BF);
    apb(1'b0, OFS_WAKE6, 0);
    chk(rd, 32'h0000_00FF);
    apb(1'b0, OFS_WDT_SLEEP, 0);
    chk(rd, 32'h0000_0031);
    apb(1'b0, OFS_INT_FLAG, 0);
    chk(rd & 32'h09, 32'h0);
    apb(1'b0, OFS_INT_MASK, 0);
    chk(rd & 32'h09, 32'h0);
    apb(1'b0, OFS_STATUS, 0);
    chk(rd & 32'h78, 32'h18);
    apb(1'b0, OFS_BANK, 0);
    chk(rd & 32'hC0, 32'h0);
    apb(1'b0, 8'h40, 0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, OFS_CAUSE, 0);
    chk(rd, 32'h0000_0009);
    $display("power-on test done");
  endtask

  task automatic t_pin_reset();
    apb(1'b1, OFS_STATUS, 32'h60);
    apb(1'b1, OFS_BANK, 32'hC0);
    apb(1'b1, OFS_OPTION, 32'h00);
    apb(1'b1, OFS_WAKE6, 32'h00);
    apb(1'b1, OFS_INT_MASK, 32'h09);
    pin_reset();
    apb(1'b0, OFS_STATUS, 0);
    chk(rd & 32'h60, 32'h60);
    apb(1'b0, OFS_BANK, 0);
    chk(rd & 32'hC0, 32'hC0);
    apb(1'b0, OFS_OPTION, 0);
    chk(rd, 32'h0000_00BF);
    apb(1'b0, OFS_WAKE6, 0);
    chk(rd, 32'h0000_00FF);
    apb(1'b0, OFS_INT_MASK, 0);
    chk(rd & 32'h09, 32'h0);
    apb(1'b0, OFS_CAUSE, 0);
    chk(rd, 32'h0000_000A);
    $display("pin reset test done");
  endtask

  task automatic t_sleep1();
    apb(1'b1, OFS_WAKE6, 32'h00);
    pulse(1'b1);
    @(posedge pclk);
    chk({cpu_stall, osc_enable}, 2'b10);
    apb(1'b0, OFS_STATUS, 0);
    chk(rd & 32'h18, 32'h10);
    port6_wake_pins <= 8'h00;
    repeat (60) @(posedge pclk);
    chk({cpu_stall, osc_enable, cpu_reset}, 3'b100);
    port6_wake_pins <= 8'hFF;
    pin_reset();
    apb(1'b0, OFS_STATUS, 0);
    chk(rd & 32'h18, 32'h10);
    $display("sleep 1 test done");
  endtask

  task automatic t_watchdog();
    apb(1'b1, OFS_OPTION, 32'h00);
    watchdog_code_option <= 1'b0;
    pulse(1'b0);
    wait_sig(cpu_reset, 1'b1, 80, n);
    chk(n >= 20, 1'b1);
    watchdog_code_option <= 1'b1;
    wait_sig(cpu_stall, 1'b0, OSCILLATOR_STARTUP_TIMER + 12, n);
    apb(1'b0, OFS_STATUS, 0);
    chk(rd & 32'h18, 32'h08);
    apb(1'b0, OFS_CAUSE, 0);
    chk(rd, 32'h0000_000C);
    $display("watchdog test done");
  endtask

  task automatic t_sleep2();
    apb(1'b1, OFS_OPTION, 32'h0F);
    apb(1'b1, OFS_WAKE6, 32'hFE);
    apb(1'b1, OFS_WDT_SLEEP, 32'h01);
    chk({cpu_stall, osc_enable}, 2'b10);
    port6_wake_pins <= 8'hFD;
    repeat (20) @(posedge pclk);
    chk(osc_enable, 1'b0);
    watchdog_code_option <= 1'b0;
    m = rst_seen;
    port6_wake_pins <= 8'hFC;
    wait_sig(osc_enable, 1'b1, 8, n);
    port6_wake_pins <= 8'hFF;
    wait_sig(cpu_stall, 1'b0, OSCILLATOR_STARTUP_TIMER + 12, n);
    chk(rst_seen, m);
    apb(1'b0, OFS_WDT_SLEEP, 0);
    chk(rd, 32'h0000_0031);
    apb(1'b1, OFS_WDT_SLEEP, 32'h11);
    watchdog_code_option <= 1'b1;
    apb(1'b0, OFS_STATUS, 0);
    chk(rd & 32'h18, 32'h10);
    apb(1'b1, OFS_WDT_SLEEP, 32'h00);
    chk(osc_enable, 1'b0);
    port7_wake_pins <= 2'b01;
    wait_sig(osc_enable, 1'b1, 8, n);
    port7_wake_pins <= 2'b11;
    wait_sig(cpu_stall, 1'b0, OSCILLATOR_STARTUP_TIMER + 12, n);
    apb(1'b0, OFS_WDT_SLEEP, 0);
    chk(rd, 32'h0000_0010);
    apb(1'b1, OFS_WDT_SLEEP, 32'h01);
    chk(osc_enable, 1'b0);
    apb(1'b1, OFS_WDT_SLEEP, 32'h11);
    wait_sig(osc_enable, 1'b1, 8, n);
    wait_sig(cpu_stall, 1'b0, OSCILLATOR_STARTUP_TIMER + 12, n);
    chk(rst_seen, m);
    apb(1'b1, OFS_WDT_SLEEP, 32'h01);
    pin_reset();
    chk(rst_seen > m, 1'b1);
    $display("sleep 2 test done");
  endtask

  initial
  begin
    fails = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sleep_instruction = 1'b0;
    watchdog_clear = 1'b0;
    reset_pin_n = 1'b1;
    port6_wake_pins = 8'hFF;
    port7_wake_pins = 2'b11;
    watchdog_code_option = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_power_on();
    t_pin_reset();
    t_sleep1();
    t_watchdog();
    t_sleep2();
    tally_and_finish();
  end
endmodule // rst_sleep_ctrl_tb
